// ---- common/nscst_map.vh ----
// nscst_map.vh: constants for the node switch configuration and self-test block
// assumes plain inclusion by bare name; definitions only
`ifndef NSCST_MAP_VH
`define NSCST_MAP_VH

// switch blank encoding (switch presented with a separate blank flag)
`define NSCST_OCT1_DEF      8'hc0
`define NSCST_OCT1_MIN      8'hc0
`define NSCST_OCT1_MAX      8'hdf
`define NSCST_OCT2_DEF      8'ha8
`define NSCST_OCT3_DEF      8'hfa
`define NSCST_OCT4_DEF      8'h01
`define NSCST_OCT4_MIN      8'h01
`define NSCST_OCT4_MAX      8'hfe
`define NSCST_OCT_LOW       8'h00
`define NSCST_OCT_HIGH      8'hff

// octet width and count of address octets
`define NSCST_OCT_W         8
`define NSCST_OCT_N         4

// operating modes on switch five
`define NSCST_MODE_ONLINE   3'h0
`define NSCST_MODE_OFFLINE  3'h1
`define NSCST_MODE_LOOP     3'h2
`define NSCST_MODE_HWTEST   3'h3
`define NSCST_MODE_AUTONEG  3'h4

// test duration in milliseconds and clock rate in kHz
`define NSCST_TEST_MS       5000
`define NSCST_CLK_KHZ       40000

// io points occupied in host space
`define NSCST_IO_POINTS     6'h20

`endif

// ---- rtl/nscst_sw_check.v ----
// nscst_sw_check.v: blank-default and range check of one address octet
// assumes switch value and blank flag are stable while sampled
`timescale 1ns/1ps
`default_nettype none

module nscst_sw_check #(
  parameter [7:0] DEF_VAL = 8'h00,
  parameter [7:0] MIN_VAL = 8'h00,
  parameter [7:0] MAX_VAL = 8'hff
) (
  // switch in
  input  wire [7:0] sw_val,
  input  wire       sw_blank,
  // result
  output wire [7:0] oct_val,
  output wire       oct_ok
);

  // blank takes the default, which is always in range
  assign oct_val = sw_blank ? DEF_VAL : sw_val;
  assign oct_ok  = (oct_val >= MIN_VAL) && (oct_val <= MAX_VAL);

endmodule

`default_nettype wire

// ---- rtl/nscst_top.v ----
// nscst_top.v: start-up switch loading, mode selection and self-test control
// assumes clock and reset come from the host rack; the cpu reset is arst_n
// assumes test engines (ram/rom, loopback) are outside and report pass/fail
// assumes loop_done may be a level or a single-cycle pulse
//
// Notes on behaviour
// R1 - octet one from switch one, blank gives 192
// R2 - octet one accepted only 192 to 223, else switch error
// R3 - octet two from switch two, 0 to 255, blank gives 168
// R4 - octet three from switch three, 0 to 255, blank gives 250
// R5 - node number from switch four, 1 to 254, blank gives 1
// R6 - switch five selects online, offline, loopback, hardware test, autonegotiation; here autonegotiation is a switch error when FAST_PORT is 0
// R7 - offline mode keeps node detached from the network
// R8 - only autonegotiation mode may run 100 Mbit/s, if port supports it
// R9 - hardware test runs with run and link on, error off
// R10 - after about 5 s show pass or fault on indicators
// R11 - operator repeats a failed hardware test before condemning it
// R12 - loopback test never blocks the line; may run past 5 s
// R13 - valid switches give module ready after reset
// R14 - invalid switches keep module ready low
// R15 - block occupies 32 io points in host space
// R16 - host clears outputs and stops on hardware error by default
// R17 - configuration tool takes hexadecimal entry by default
// R18 - switches sampled only at reset, held until next reset
`timescale 1ns/1ps
`default_nettype none
`include "nscst_map.vh"

module nscst_top #(
  parameter        FAST_PORT = 1,
  parameter [31:0] TEST_CYC  = `NSCST_TEST_MS * `NSCST_CLK_KHZ
) (
  // clock and reset
  input  wire        clock,
  input  wire        arst_n,
  // configuration switches with blank flags
  input  wire [7:0]  sw1_val,
  input  wire        sw1_blank,
  input  wire [7:0]  sw2_val,
  input  wire        sw2_blank,
  input  wire [7:0]  sw3_val,
  input  wire        sw3_blank,
  input  wire [7:0]  sw4_val,
  input  wire        sw4_blank,
  input  wire [7:0]  sw5_val,
  input  wire        sw5_blank,
  // self-test results from test engines
  input  wire        hw_test_fail,
  input  wire        loop_done,
  input  wire        loop_fail,
  // configuration out
  output reg  [31:0] ip_addr_r,
  output reg  [2:0]  op_mode_r,
  output reg         net_join_r,
  output reg         speed_100_en_r,
  output reg         hw_test_run_r,
  output reg         loop_test_run_r,
  output reg  [5:0]  io_points_r,
  // indicators and host status
  output reg         run_indicator_r,
  output reg         link_indicator_r,
  output reg         error_indicator_r,
  output reg         module_ready_input_r
);

  // sequence states
  localparam [2:0] ST_LOAD = 3'h0;
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_HWT  = 3'h2;
  localparam [2:0] ST_LPT  = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [2:0] ST_BAD  = 3'h5;

  // octet limits packed octet one first; octets two and three take any value
  localparam [31:0] OCT_DEF = {`NSCST_OCT1_DEF, `NSCST_OCT2_DEF, `NSCST_OCT3_DEF, `NSCST_OCT4_DEF};
  localparam [31:0] OCT_MIN = {`NSCST_OCT1_MIN, `NSCST_OCT_LOW, `NSCST_OCT_LOW, `NSCST_OCT4_MIN};
  localparam [31:0] OCT_MAX = {`NSCST_OCT1_MAX, `NSCST_OCT_HIGH, `NSCST_OCT_HIGH, `NSCST_OCT4_MAX};
  localparam        OCT_W   = `NSCST_OCT_W;
  localparam        OCT_N   = `NSCST_OCT_N;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [31:0] tmr_r;
  reg         fail_r;
  reg         loop_seen_r;

  wire [31:0] sw_oct_val;
  wire [3:0]  sw_oct_blank;
  wire [31:0] oct_all;
  wire [3:0]  ok_all;
  wire [7:0]  mode_raw;
  wire [2:0]  mode_now;
  wire        mode_ok;

  // modes that put the node on the network; shared by join and link decoding
  function mode_joins(input [2:0] mode);
    mode_joins = (mode == `NSCST_MODE_ONLINE) || (mode == `NSCST_MODE_AUTONEG);
  endfunction

  // switch one lands in the top octet, so index three is octet one
  assign sw_oct_val   = {sw1_val, sw2_val, sw3_val, sw4_val};
  assign sw_oct_blank = {sw1_blank, sw2_blank, sw3_blank, sw4_blank};

  // R1 R2 R3 R4 R5 octet defaults and ranges
  genvar g;
  generate
    for (g = 0; g < OCT_N; g = g + 1) begin : g_oct
      nscst_sw_check #(
        .DEF_VAL (OCT_DEF[OCT_W*g +: OCT_W]),
        .MIN_VAL (OCT_MIN[OCT_W*g +: OCT_W]),
        .MAX_VAL (OCT_MAX[OCT_W*g +: OCT_W])
      ) u_oct (
        .sw_val   (sw_oct_val[OCT_W*g +: OCT_W]),
        .sw_blank (sw_oct_blank[g]),
        .oct_val  (oct_all[OCT_W*g +: OCT_W]),
        .oct_ok   (ok_all[g])
      );
    end
  endgenerate

  // R6 mode decode, blank means online; autoneg needs the fast port
  assign mode_raw = sw5_blank ? {5'h00, `NSCST_MODE_ONLINE} : sw5_val;
  assign mode_ok  = (mode_raw <= {5'h00, `NSCST_MODE_HWTEST}) ||
                    ((mode_raw == {5'h00, `NSCST_MODE_AUTONEG}) && (FAST_PORT != 0));
  // R18 after the load cycle the latched mode rules, so later switch moves are ignored
  assign mode_now = (state_r == ST_LOAD) ? mode_raw[2:0] : op_mode_r;

  // next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_LOAD: begin
        // R14 any bad switch parks the block
        if (!((&ok_all) && mode_ok))
          state_nxt = ST_BAD;
        else if (mode_raw[2:0] == `NSCST_MODE_HWTEST)
          state_nxt = ST_HWT;
        else if (mode_raw[2:0] == `NSCST_MODE_LOOP)
          state_nxt = ST_LPT;
        else
          state_nxt = ST_RUN;
      end
      // R10 result after the test time
      ST_HWT: if (tmr_r == TEST_CYC - 32'h1) state_nxt = ST_DONE;
      // R12 loopback waits for the engine; collisions may stretch it
      // a done pulse that arrives before the minimum time is remembered
      ST_LPT: if ((loop_done || loop_seen_r) && tmr_r >= TEST_CYC - 32'h1) state_nxt = ST_DONE;
      ST_RUN, ST_DONE, ST_BAD: state_nxt = state_r;
      default: state_nxt = ST_BAD;
    endcase
  end

  // state, timer and latched fail
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_LOAD;
      tmr_r   <= 32'h0;
      fail_r  <= 1'b0;
      loop_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // timer saturates, so a very long loopback cannot wrap into a short count
      if ((state_r == ST_HWT || state_r == ST_LPT) && tmr_r != 32'hffffffff)
        tmr_r <= tmr_r + 32'h1;
      // done may be a single pulse, so keep it until the minimum time is up
      if (state_r == ST_LPT && loop_done)
        loop_seen_r <= 1'b1;
      // fault latches so a late pass cannot hide it
      if ((state_r == ST_HWT && hw_test_fail) || (state_r == ST_LPT && loop_done && loop_fail))
        fail_r <= 1'b1;
    end
  end

  // R18 configuration captured once, in the load cycle after reset release
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ip_addr_r   <= 32'h0;
      op_mode_r   <= `NSCST_MODE_OFFLINE;
      io_points_r <= 6'h00;
    end else if (state_r == ST_LOAD) begin
      ip_addr_r   <= oct_all;
      op_mode_r   <= mode_raw[2:0];
      // R15 fixed io occupation
      io_points_r <= `NSCST_IO_POINTS;
    end
  end

  // outputs per state; all registered
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      net_join_r           <= 1'b0;
      speed_100_en_r       <= 1'b0;
      hw_test_run_r        <= 1'b0;
      loop_test_run_r      <= 1'b0;
      run_indicator_r      <= 1'b0;
      link_indicator_r     <= 1'b0;
      error_indicator_r    <= 1'b0;
      module_ready_input_r <= 1'b0;
    end else begin
      // decoded from mode_now, not the live switch, so moved switches cannot flip outputs
      // R7 offline and test modes stay off the network
      net_join_r      <= (state_nxt == ST_RUN) && mode_joins(mode_now);
      // R8 fast rate only in autoneg mode on the fast port
      speed_100_en_r  <= (state_nxt == ST_RUN) && (mode_now == `NSCST_MODE_AUTONEG) && (FAST_PORT != 0);
      // test strobes for the outside engines follow the state
      hw_test_run_r   <= (state_nxt == ST_HWT);
      loop_test_run_r <= (state_nxt == ST_LPT);
      // R9 test running: run and link on, error off
      // run stays lit after a test so the result can be read
      run_indicator_r  <= (state_nxt != ST_BAD) && (state_nxt != ST_LOAD);
      link_indicator_r <= (state_nxt == ST_HWT) || (state_nxt == ST_LPT) ||
                          ((state_nxt == ST_RUN) && mode_joins(mode_now));
      // R10 pass or fault shown on error indicator
      error_indicator_r <= (state_nxt == ST_BAD) || ((state_nxt == ST_DONE) && (fail_r ||
                           (state_r == ST_HWT && hw_test_fail) ||
                           (state_r == ST_LPT && loop_done && loop_fail)));
      // R13 R14 ready only with valid switches
      module_ready_input_r <= (state_nxt != ST_BAD) && (state_nxt != ST_LOAD);
    end
  end

endmodule

`default_nettype wire

// ---- verification/nscst_engine_model.sv ----
// nscst_engine_model.sv: stand-in for the ram/rom and loopback engines
// assumes the bench sets fail_cmd before each reset
`timescale 1ns/1ps
`default_nettype none
module nscst_engine_model (
  // control
  input  wire logic clock,
  input  wire logic loop_run,
  input  wire logic fail_cmd,
  // results
  output var  logic hw_fail,
  output var  logic loop_done,
  output var  logic loop_fail
);
  logic [5:0] cnt_r = 6'h00;
  // slow loopback
  // heavy traffic modelled: done comes well after the nominal time
  always @(posedge clock) begin
    cnt_r <= loop_run ? cnt_r + 6'h01 : 6'h00;
    loop_done <= loop_run && cnt_r > 6'h1e;
  end
  // loopback result toggles when not qualified by done; hardware result follows fail_cmd
  assign hw_fail = fail_cmd;
  assign loop_fail = loop_done ? fail_cmd : cnt_r[0];
endmodule
`default_nettype wire

// ---- verification/nscst_top_asserts.sv ----
// nscst_top_asserts.sv: port checks on nscst_top
// assumes bind into nscst_top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module nscst_top_asserts #(
  parameter [31:0] TEST_CYC = 32'd20
) (
  // clock and reset
  input wire        clock,
  input wire        arst_n,
  // outputs watched
  input wire [31:0] ip_addr_r,
  input wire [2:0]  op_mode_r,
  input wire        net_join_r,
  input wire        speed_100_en_r,
  input wire        hw_test_run_r,
  input wire        run_indicator_r,
  input wire        link_indicator_r,
  input wire        error_indicator_r,
  input wire        module_ready_input_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  reg [31:0] hw_cnt_r;
  // length of the running hardware test
  always @(posedge clock or negedge arst_n)
    if (!arst_n) hw_cnt_r <= 32'h0;
    else hw_cnt_r <= hw_test_run_r ? hw_cnt_r + 32'h1 : 32'h0;
  sequence s_hw_fall;
    $fell(hw_test_run_r);
  endsequence
  sequence s_hw_pass_leds;
    run_indicator_r && !link_indicator_r;
  endsequence
  chk_oct1_class: assert property (module_ready_input_r |-> ip_addr_r[31:29] == 3'h6)
    else $error("octet one not class c");
  chk_node_range: assert property (module_ready_input_r |-> ip_addr_r[7:0] != 8'h00 && ip_addr_r[7:0] != 8'hff)
    else $error("node number out of range");
  chk_offline_detach: assert property (op_mode_r == 3'h1 |-> !net_join_r)
    else $error("offline node joined");
  chk_fast_mode: assert property (speed_100_en_r |-> op_mode_r == 3'h4)
    else $error("fast speed outside autoneg");
  chk_hw_leds: assert property (hw_test_run_r |-> run_indicator_r && link_indicator_r && !error_indicator_r)
    else $error("leds wrong during test");
  chk_hw_result: assert property (s_hw_fall |-> s_hw_pass_leds)
    else $error("leds wrong after test");
  chk_hw_len: assert property (s_hw_fall |-> hw_cnt_r == TEST_CYC)
    else $error("hardware test too short");
  chk_hw_max: assert property (hw_test_run_r |-> hw_cnt_r <= TEST_CYC)
    else $error("hardware test too long");
  chk_cfg_hold: assert property (module_ready_input_r |=> $stable(ip_addr_r) && $stable(op_mode_r))
    else $error("configuration changed");
endmodule
bind nscst_top nscst_top_asserts #(.TEST_CYC(TEST_CYC)) u_chk (.clock, .arst_n, .ip_addr_r,
  .op_mode_r, .net_join_r, .speed_100_en_r, .hw_test_run_r, .run_indicator_r,
  .link_indicator_r, .error_indicator_r, .module_ready_input_r);
`default_nettype wire

// ---- verification/nscst_top_tb_top.sv ----
// nscst_top_tb_top.sv: self-checking bench for nscst_top
// assumes TEST_CYC shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module nscst_top_tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        fail_cmd = 1'b0;
  logic [39:0] sw = 40'h0;
  logic [4:0]  bl = 5'h1f;
  logic [39:0] bad [4] = '{40'he000000100, 40'hc000000000, 40'hc00000ff00, 40'hc000000105};
  wire  [31:0] ip;
  wire  [2:0]  md;
  wire  [5:0]  io;
  wire         jn, spd, hwr, lpr, run, link_indicator, err, rdy, hwf, ldn, lfl;
  wire  [5:0]  led = {jn, spd, rdy, run, link_indicator, err};
  int          n_mismatch = 0;
  int          checked = 0;
  always #12.5 clock = ~clock;
  nscst_top #(.TEST_CYC(32'd20)) i_dut (.clock(clock), .arst_n(arst_n),
    .sw1_val(sw[39:32]), .sw1_blank(bl[4]), .sw2_val(sw[31:24]), .sw2_blank(bl[3]),
    .sw3_val(sw[23:16]), .sw3_blank(bl[2]), .sw4_val(sw[15:8]), .sw4_blank(bl[1]),
    .sw5_val(sw[7:0]), .sw5_blank(bl[0]), .hw_test_fail(hwf), .loop_done(ldn),
    .loop_fail(lfl), .ip_addr_r(ip), .op_mode_r(md), .net_join_r(jn), .speed_100_en_r(spd),
    .hw_test_run_r(hwr), .loop_test_run_r(lpr), .io_points_r(io), .run_indicator_r(run),
    .link_indicator_r(link_indicator), .error_indicator_r(err), .module_ready_input_r(rdy));
  nscst_engine_model i_eng (.clock(clock), .loop_run(lpr), .fail_cmd(fail_cmd),
    .hw_fail(hwf), .loop_done(ldn), .loop_fail(lfl));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input logic [46:0] g, input logic [46:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // switches set while reset is low, loaded at first edge after release
  task automatic boot(input logic [39:0] v, input logic [4:0] b, input logic f);
    @(posedge clock);
    arst_n <= 1'b0;
    sw <= v;
    bl <= b;
    fail_cmd <= f;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
  endtask
  // bounded wait for the running test to finish
  task automatic wend;
    int i;
    for (i = 0; i < 200 && (hwr || lpr); i++) @(posedge clock);
    if (i == 200) begin
      n_mismatch++;
      $display("[ERR] %0t test did not finish", $time);
      test_done;
    end else
      #1;
  endtask
  initial begin
    boot(40'h0, 5'h1f, 1'b0);
    ck({ip, md, io, led}, {32'hc0a8fa01, 3'h0, 6'h20, 6'h2e});
    $display("test blank done");
    boot(40'hdf00fffe04, 5'h0, 1'b0); // switch values entered in hexadecimal
    ck({ip, md, io, led}, {32'hdf00fffe, 3'h4, 6'h20, 6'h3e});
    @(posedge clock);
    sw <= ~sw;
    repeat (3) @(posedge clock);
    #1;
    ck({ip, md, led}, {32'hdf00fffe, 3'h4, 6'h3e});
    $display("test limits done");
    boot(40'h01, 5'h1e, 1'b0);
    ck({ip, md, led}, {32'hc0a8fa01, 3'h1, 6'h0c});
    $display("test offline done");
    foreach (bad[k]) begin
      boot(bad[k], 5'h0, 1'b0);
      ck(led, 6'h01);
    end
    $display("test bad switches done");
    // failing run first, then the repeat that passes
    for (int k = 0; k < 2; k++) begin
      boot(40'h03, 5'h1e, k == 0); // host stops and restarts after a hardware error
      ck({hwr, led}, {1'b1, 6'h0e});
      wend;
      ck({hwr, led}, {1'b0, 5'h06, k == 0});
    end
    $display("test hardware done");
    // failing loopback first, then a passing one
    for (int k = 0; k < 2; k++) begin
      boot(40'h02, 5'h1e, k == 0); // host restarts after the fault
      ck({lpr, led}, {1'b1, 6'h0e});
      wend;
      ck({lpr, led}, {1'b0, 5'h06, k == 0});
    end
    $display("test loopback done");
    test_done;
  end
endmodule
`default_nettype wire
